// File: sph_handshake.sv
// Purpose: Status-word side of the process-data handshake of a serial terminal.
// Assumes: Receiver and transmitter logic run on the same clock as this block.
// Notes:   Handshake bits are compared only on the process-data cycle strobe.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Flip-flop FIFO with valid and ready on both sides.
module sph_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // Clock, reset and flush.
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         flush,
   // Fill side.
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Drain side.
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   // One spare pointer bit tells full from empty without a separate count.
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
   logic         push, pop;

   always_comb begin
      in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
      out_valid = wr_q != rd_q;
      out_data  = mem_q[rd_q[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wr_d      = flush ? '0 : wr_q + (AW+1)'(push);
      rd_d      = flush ? '0 : rd_q + (AW+1)'(pop);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Handshake engine between the controller's command word and the FIFOs.
module sph_handshake #(
   parameter int MAX_BYTES = sph_pkg::MAX_LARGE,
   parameter int DEPTH     = sph_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic                                     clock,
   input  wire logic                                     rst,
   // Process image from the controller.
   input  wire logic                                     pd_cycle,
   input  wire sph_pkg::sph_image_t                      image_mode,
   input  wire logic [15:0]                              controller_command_word,
   input  wire logic [MAX_BYTES-1:0][sph_pkg::BYTE_W-1:0] host_output_bytes,
   // Process image to the controller.
   output logic [15:0]                                   terminal_status_word,
   output logic [MAX_BYTES-1:0][sph_pkg::BYTE_W-1:0]     host_input_bytes,
   // Serial receiver characters.
   input  wire logic                                     rx_valid,
   input  wire sph_pkg::sph_rx_char_t                    rx_char,
   // Serial transmitter characters.
   output logic                                          tx_valid,
   output logic [sph_pkg::BYTE_W-1:0]                    tx_data,
   input  wire logic                                     tx_ready,
   // Line control.
   output logic                                          line_block,
   output logic                                          line_reload
);
   import sph_pkg::*;

   sph_state_t               state_q, state_d;
   logic [IDX_W-1:0]         idx_q, idx_d, len_q, len_d, il_q, il_d;
   logic                     init_q, init_d, ia_q, ia_d;
   logic                     ta_q, ta_d, rr_q, rr_d;
   logic                     par_q, par_d, frm_q, frm_d, ovr_q, ovr_d;
   logic                     reload_q, reload_d;
   logic [15:0]              sw_q, sw_d;
   logic [MAX_BYTES-1:0][BYTE_W-1:0] in_buf_q, in_buf_d;
   logic [IDX_W-1:0]         max_len, req_len;
   logic                     rx_push, rx_in_ready, rx_out_valid, rx_out_ready;
   logic [BYTE_W-1:0]        rx_out_data;
   logic                     tx_in_valid, tx_in_ready, tx_out_valid;
   logic                     batch_done;

   // Bad characters never reach the FIFO, so the controller sees only clean data.
   assign rx_push = rx_valid && !rx_char.parity_err && !rx_char.framing_err && !init_q;

   sph_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_rx_fifo (
      .clock     (clock),
      .rst       (rst),
      .flush     (init_q),
      .in_valid  (rx_push),
      .in_data   (rx_char.data),
      .in_ready  (rx_in_ready),
      .out_valid (rx_out_valid),
      .out_data  (rx_out_data),
      .out_ready (rx_out_ready)
   );

   // The transmitter is held off during init so a half-flushed FIFO is never sent.
   sph_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_tx_fifo (
      .clock     (clock),
      .rst       (rst),
      .flush     (init_q),
      .in_valid  (tx_in_valid),
      .in_data   (host_output_bytes[idx_q]),
      .in_ready  (tx_in_ready),
      .out_valid (tx_out_valid),
      .out_data  (tx_data),
      .out_ready (tx_ready && !init_q)
   );
   assign tx_valid = tx_out_valid && !init_q;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d  = state_q;
      idx_d    = idx_q;
      len_d    = len_q;
      il_d     = il_q;
      init_d   = init_q;
      ia_d     = ia_q;
      ta_d     = ta_q;
      rr_d     = rr_q;
      in_buf_d = in_buf_q;
      reload_d = 1'b0;
      batch_done   = 1'b0;
      tx_in_valid  = 1'b0;
      rx_out_ready = 1'b0;
      max_len  = sph_max_bytes(image_mode);
      if (image_mode == SPH_IMG_LARGE) begin
         // A count above the image limit is clamped rather than wrapped into a small one.
         if (controller_command_word[CW_OL_LO +: BYTE_W] > BYTE_W'(max_len)) begin
            req_len = max_len;
         end else begin
            req_len = controller_command_word[CW_OL_LO +: IDX_W];
         end
      end else begin
         req_len = IDX_W'(controller_command_word[CW_OLS_LO +: 3]);
      end
      if (req_len > max_len) begin
         req_len = max_len;
      end
      if (pd_cycle && controller_command_word[CW_IR]) begin
         if (!init_q) begin
            reload_d = 1'b1;
         end
         init_d  = 1'b1;
         state_d = SPH_ST_IDLE;
      end else if (pd_cycle && init_q) begin
         // Adopt the controller's toggles so no stale transfer is seen afterwards.
         init_d = 1'b0;
         ia_d   = 1'b0;
         ta_d   = controller_command_word[CW_TR];
         rr_d   = controller_command_word[CW_RA];
      end else begin
         case (state_q)
            SPH_ST_IDLE: begin
               if (pd_cycle && (controller_command_word[CW_TR] != ta_q)) begin
                  idx_d = '0;
                  len_d = req_len;
                  if (req_len == '0) begin
                     ta_d = ~ta_q;
                  end else begin
                     state_d = SPH_ST_LOAD;
                  end
               end else if (pd_cycle && (controller_command_word[CW_RA] == rr_q)
                            && rx_out_valid) begin
                  idx_d   = '0;
                  state_d = SPH_ST_DRAIN;
               end
            end
            SPH_ST_LOAD: begin
               // A full transmit FIFO stalls loading, and so the acknowledge.
               tx_in_valid = 1'b1;
               if (tx_in_ready) begin
                  idx_d = idx_q + IDX_W'(1);
                  if (idx_d == len_q) begin
                     ta_d    = ~ta_q;
                     state_d = SPH_ST_IDLE;
                  end
               end
            end
            SPH_ST_DRAIN: begin
               // The batch ends when the FIFO runs dry or the image limit is reached.
               if (rx_out_valid && (idx_q < max_len)) begin
                  rx_out_ready     = 1'b1;
                  in_buf_d[idx_q]  = rx_out_data;
                  idx_d            = idx_q + IDX_W'(1);
               end else begin
                  il_d       = idx_q;
                  rr_d       = ~rr_q;
                  batch_done = 1'b1;
                  state_d    = SPH_ST_IDLE;
               end
            end
            default: begin
               state_d = SPH_ST_IDLE;
            end
         endcase
      end
      // Flush takes one cycle; the flag follows once the pointers are clear.
      if (init_q && init_d) begin
         ia_d = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error flags: an event in the clearing cycle survives the clear.
   // Reception is off while the line is blocked, so errors seen then are not reported.
   always_comb begin
      par_d = (par_q && !batch_done && !init_q) || (rx_valid && rx_char.parity_err && !init_q);
      frm_d = (frm_q && !batch_done && !init_q) || (rx_valid && rx_char.framing_err && !init_q);
      ovr_d = (ovr_q && !batch_done && !init_q) || (rx_push && !rx_in_ready);
      sw_d  = SW_RESET;
      sw_d[SW_TA]   = ta_q;
      sw_d[SW_RR]   = rr_q;
      sw_d[SW_IA]   = ia_q;
      sw_d[SW_FULL] = !rx_in_ready;
      if (image_mode == SPH_IMG_LARGE) begin
         sw_d[SW_PAR] = par_q;
         sw_d[SW_FRM] = frm_q;
         sw_d[SW_OVR] = ovr_q;
         sw_d[SW_IL_LO +: 8] = 8'(il_q);
      end else begin
         sw_d[SW_ILS_LO +: 3] = il_q[2:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q  <= SPH_ST_IDLE;
         idx_q    <= '0;
         len_q    <= '0;
         il_q     <= '0;
         init_q   <= 1'b0;
         ia_q     <= 1'b0;
         ta_q     <= 1'b0;
         rr_q     <= 1'b0;
         par_q    <= 1'b0;
         frm_q    <= 1'b0;
         ovr_q    <= 1'b0;
         reload_q <= 1'b0;
         sw_q     <= SW_RESET;
         in_buf_q <= '0;
      end else begin
         state_q  <= state_d;
         idx_q    <= idx_d;
         len_q    <= len_d;
         il_q     <= il_d;
         init_q   <= init_d;
         ia_q     <= ia_d;
         ta_q     <= ta_d;
         rr_q     <= rr_d;
         par_q    <= par_d;
         frm_q    <= frm_d;
         ovr_q    <= ovr_d;
         reload_q <= reload_d;
         sw_q     <= sw_d;
         in_buf_q <= in_buf_d;
      end
   end

   assign terminal_status_word = sw_q;
   assign host_input_bytes     = in_buf_q;
   assign line_block           = init_q;
   assign line_reload          = reload_q;
endmodule
`default_nettype wire

// File: sph_pkg.sv
// Purpose: Shared constants and types for the process-image handshake block.
// Assumes: One 100 MHz clock; the process-data cycle arrives as a strobe.
// Notes:   Bit positions of the status and command words live here.
`default_nettype none
package sph_pkg;
   localparam int CLK_MHZ     = 100;
   localparam int BYTE_W      = 8;
   localparam int MAX_LARGE   = 22;
   localparam int MAX_MEDIUM  = 6;
   localparam int MAX_SMALL   = 4;
   localparam int FIFO_DEPTH  = 16;
   localparam int IDX_W       = 5;
   // Status word bit positions.
   localparam int SW_TA       = 0;
   localparam int SW_RR       = 1;
   localparam int SW_IA       = 2;
   localparam int SW_FULL     = 3;
   localparam int SW_PAR      = 4;
   localparam int SW_FRM      = 5;
   localparam int SW_OVR      = 6;
   localparam int SW_ILS_LO   = 4;
   localparam int SW_IL_LO    = 8;
   // Command word bit positions.
   localparam int CW_TR       = 0;
   localparam int CW_RA       = 1;
   localparam int CW_IR       = 2;
   localparam int CW_OLS_LO   = 4;
   localparam int CW_OL_LO    = 8;
   localparam logic [15:0] SW_RESET = 16'h0000;

   typedef enum logic [1:0] {
      SPH_IMG_SMALL  = 2'b00,
      SPH_IMG_MEDIUM = 2'b01,
      SPH_IMG_LARGE  = 2'b10
   } sph_image_t;

   typedef enum logic [1:0] {
      SPH_ST_IDLE  = 2'b00,
      SPH_ST_LOAD  = 2'b01,
      SPH_ST_DRAIN = 2'b10
   } sph_state_t;

   typedef struct packed {
      logic [BYTE_W-1:0] data;
      logic              parity_err;
      logic              framing_err;
   } sph_rx_char_t;

   // Largest byte count that one batch may carry in the given image.
   function automatic logic [IDX_W-1:0] sph_max_bytes(input sph_image_t img);
      case (img)
         SPH_IMG_LARGE:  sph_max_bytes = IDX_W'(MAX_LARGE);
         SPH_IMG_MEDIUM: sph_max_bytes = IDX_W'(MAX_MEDIUM);
         default:        sph_max_bytes = IDX_W'(MAX_SMALL);
      endcase
   endfunction
endpackage
`default_nettype wire

// File: sph_handshake_asserts.sv
// Purpose: Concurrent checks on the ports of the process-image handshake block.
// Assumes: One clock domain; synchronous active-high reset.
// Notes:   Status latency is allowed one to four edges for init and one to three for error flags, as the design registers errors twice and init three times.
`default_nettype none
module sph_handshake_asserts #(
   parameter int MAX_BYTES = sph_pkg::MAX_LARGE,
   parameter int DEPTH     = sph_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic                  clock,
   input  wire logic                  rst,
   // Controller side.
   input  wire logic                  pd_cycle,
   input  wire sph_pkg::sph_image_t   image_mode,
   input  wire logic [15:0]           controller_command_word,
   input  wire logic [15:0]           terminal_status_word,
   // Serial side.
   input  wire logic                  rx_valid,
   input  wire sph_pkg::sph_rx_char_t rx_char,
   input  wire logic                  tx_valid,
   input  wire logic                  tx_ready,
   input  wire logic                  line_block
);
   timeunit 1ns;
   timeprecision 100ps;
   import sph_pkg::*;
   wire logic [15:0] sw = terminal_status_word;
   wire logic [15:0] cw = controller_command_word;
   wire logic        lg = image_mode == SPH_IMG_LARGE;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   chk_nibble_count: assert property (
      $changed(sw[SW_RR]) && !lg |-> sw[15:7] == 9'h000 && sw[6:4] != 3'h0
         && (sw[6:4] <= 3'h4 || image_mode == SPH_IMG_MEDIUM && sw[6:4] <= 3'h6))
      else $error("short image count out of range");
   chk_large_count: assert property (
      $changed(sw[SW_RR]) && lg |-> sw[15:8] != 8'h00 && sw[15:8] <= 8'h16)
      else $error("large image count out of range");
   chk_init_done: assert property (
      pd_cycle && cw[CW_IR] |-> ##[1:4] sw[SW_IA]) else $error("init done flag late");
   chk_init_clear: assert property (
      pd_cycle && !cw[CW_IR] && sw[SW_IA] |-> ##[1:4] !sw[SW_IA]) else $error("init done not cleared");
   chk_init_block: assert property (
      pd_cycle && cw[CW_IR] |=> line_block && !tx_valid) else $error("line not blocked in init");
   chk_ack_follows: assert property (
      $changed(sw[SW_TA]) |-> sw[SW_TA] == cw[CW_TR]) else $error("tx ack moved away from request");
   chk_rx_wait: assert property (
      sw[SW_RR] != cw[CW_RA] && !sw[SW_IA] && !cw[CW_IR] |=> $stable(sw[SW_RR]))
      else $error("announce toggled before ack");
   chk_parity_flag: assert property (
      rx_valid && rx_char.parity_err && lg && !line_block |-> ##[1:3] sw[SW_PAR])
      else $error("parity flag not set");
   chk_overrun_flag: assert property (
      rx_valid && sw[SW_FULL] && !rx_char.parity_err && !rx_char.framing_err && lg
         && !line_block |-> ##[1:3] sw[SW_OVR]) else $error("arrival at full not flagged");
   chk_tx_loaded: assert property (
      $changed(sw[SW_TA]) && lg && cw[15:8] != 8'h00 && !tx_ready |-> tx_valid)
      else $error("tx ack with empty fifo");
endmodule
bind sph_handshake sph_handshake_asserts #(.MAX_BYTES(MAX_BYTES), .DEPTH(DEPTH)) u_chk (
   .clock(clock), .rst(rst), .pd_cycle(pd_cycle), .image_mode(image_mode),
   .controller_command_word(controller_command_word), .terminal_status_word(terminal_status_word),
   .rx_valid(rx_valid), .rx_char(rx_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .line_block(line_block));
`default_nettype wire

// File: sph_ctrl_model.sv
// Purpose: Fieldbus controller stand-in: process-data strobe and receive acknowledge.
// Assumes: Outputs change 1 ns after the rising clock edge.
// Notes:   Acknowledges promptly, or after a delay when slow is high.
`default_nettype none
module sph_ctrl_model (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Bench control.
   input  wire logic        pd_en,
   input  wire logic        slow,
   input  wire logic [15:0] cmd_in,
   // Block side.
   input  wire logic [15:0] status,
   output logic             pd_cycle,
   output logic [15:0]      cmd_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import sph_pkg::*;
   logic [1:0] tick = 2'h0;
   logic [3:0] hold = 4'h0;
   logic       ra   = 1'b0;
   assign cmd_out = {cmd_in[15:2], ra, cmd_in[0]};
   initial begin
      pd_cycle = 1'b0;
      forever begin
         @(posedge clock);
         #1;
         tick = tick + 2'h1;
         pd_cycle = pd_en && !rst && tick == 2'h0;
         // Init pattern carries only the request bit, so the ack bit is parked low.
         if (rst || cmd_in[CW_IR]) ra = 1'b0;
         else if (status[SW_RR] != ra && !status[SW_IA]) begin
            hold = hold + 4'h1;
            if (hold > (slow ? 4'h8 : 4'h0)) begin
               ra = ~ra;
               hold = 4'h0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: tb_sph_handshake.sv
// Purpose: Self-checking bench for the process-image handshake block.
// Assumes: The controller stand-in makes the process-data strobe.
// Notes:   Transmit bytes and receive batches are checked against queues.
`default_nettype none
module tb_sph_handshake;
   timeunit 1ns;
   timeprecision 100ps;
   import sph_pkg::*;
   logic                             clock, pd_cycle, tx_valid, line_block, line_reload;
   logic                             rst = 1'b1, pd_en = 1'b0, slow = 1'b0, rr_seen = 1'b0;
   logic                             rx_valid = 1'b0, tx_ready = 1'b0;
   sph_image_t                       mode = SPH_IMG_LARGE;
   sph_rx_char_t                     rx_char = '0;
   logic [15:0]                      cmd_in = 16'h0000, cmd, sw;
   logic [MAX_LARGE-1:0][BYTE_W-1:0] obytes = '0, ibytes;
   logic [7:0]                       tx_data;
   logic [31:0]                      rnd = 32'h0000_002D;
   logic [7:0]                       txq[$], rxq[$];
   int                               cntq[$];
   int                               fails = 0, num_checks = 0, k, reloads = 0;
   sph_handshake DUT (.clock(clock), .rst(rst), .pd_cycle(pd_cycle), .image_mode(mode),
      .controller_command_word(cmd), .host_output_bytes(obytes), .terminal_status_word(sw),
      .host_input_bytes(ibytes), .rx_valid(rx_valid), .rx_char(rx_char), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .line_block(line_block), .line_reload(line_reload));
   sph_ctrl_model ctrl (.clock(clock), .rst(rst), .pd_en(pd_en), .slow(slow), .cmd_in(cmd_in),
      .status(sw), .pd_cycle(pd_cycle), .cmd_out(cmd));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wait_for(input int b, input logic v);
      for (int j = 0; j < 400 && sw[b] !== v; j++) tick(1);
      if (sw[b] !== v) begin
         fails++;
         results();
      end
   endtask
   // Random stalls on the transmit side while queued results drain.
   task automatic settle();
      logic [31:0] r;
      for (int j = 0; j < 900 && txq.size() + cntq.size() > 0; j++) begin
         r = xs();
         tx_ready = r[0];
         tick(1);
      end
      tx_ready = 1'b0;
      if (txq.size() + cntq.size() > 0) begin
         fails++;
         results();
      end
   endtask
   task automatic send(input sph_image_t m, input int n);
      logic [31:0] r;
      mode = m;
      for (int i = 0; i < n; i++) begin
         r = xs();
         obytes[i] = r[7:0];
         txq.push_back(r[7:0]);
      end
      if (m == SPH_IMG_LARGE) cmd_in[15:8] = 8'(n);
      else cmd_in[6:4] = 3'(n);
      cmd_in[CW_TR] = ~cmd_in[CW_TR];
      wait_for(SW_TA, cmd_in[CW_TR]);
      check("tx fifo loaded", 16'h0001, {15'h0000, tx_valid});
      settle();
      $display("transmit of %0d bytes done", n);
   endtask
   // First two characters carry a parity and a framing error and must vanish; surplus beyond the fifo is lost.
   task automatic recv(input sph_image_t m, input int n, input int mx);
      logic [31:0] r;
      pd_en = 1'b0;
      mode = m;
      for (int i = 0; i <= n + 1; i++) begin
         r = xs();
         rx_char = {r[7:0], i == 0, i == 1};
         rx_valid = 1'b1;
         if (i > 1 && i <= FIFO_DEPTH + 1) rxq.push_back(r[7:0]);
         tick(1);
         rx_valid = 1'b0;
         tick(1);
      end
      tick(3);
      check("rx full flag", 16'(n >= FIFO_DEPTH), {15'h0000, sw[SW_FULL]});
      if (m == SPH_IMG_LARGE) check("parity flag", 16'h0001, {15'h0000, sw[SW_PAR]});
      if (m == SPH_IMG_LARGE) check("framing flag", 16'h0001, {15'h0000, sw[SW_FRM]});
      if (m == SPH_IMG_LARGE) check("overrun flag", 16'(n > FIFO_DEPTH), {15'h0000, sw[SW_OVR]});
      for (int s = (n > FIFO_DEPTH) ? FIFO_DEPTH : n; s > 0; s -= mx) cntq.push_back(s > mx ? mx : s);
      slow = r[9];
      pd_en = 1'b1;
      settle();
      $display("receive of %0d characters done", n);
   endtask
   always @(posedge clock) begin
      if (!rst && line_reload === 1'b1) reloads++;
      if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (txq.size() == 0) check("tx extra byte", 16'h0100, {8'h00, tx_data});
         else check("tx byte", {8'h00, txq.pop_front()}, {8'h00, tx_data});
      end
      if (!rst && sw[SW_RR] !== rr_seen) begin
         rr_seen = sw[SW_RR];
         k = (cntq.size() > 0) ? cntq.pop_front() : 0;
         check("rx count", 16'(k), (mode == SPH_IMG_LARGE) ? {8'h00, sw[15:8]} : {13'h0000, sw[6:4]});
         for (int i = 0; i < k; i++) check("rx byte", {8'h00, rxq.pop_front()}, {8'h00, ibytes[i]});
      end
   end
   initial begin
      tick(4);
      rst = 1'b0;
      check("status reset", SW_RESET, sw);
      pd_en = 1'b1;
      cmd_in = 16'h0004;
      wait_for(SW_IA, 1'b1);
      check("line blocked", 16'h0001, {15'h0000, line_block});
      check("reload pulses", 16'h0001, 16'(reloads));
      cmd_in = 16'h0000;
      wait_for(SW_IA, 1'b0);
      check("status ready", 16'h0000, sw);
      $display("init done");
      send(SPH_IMG_LARGE, 2);
      send(SPH_IMG_LARGE, 16);
      send(SPH_IMG_SMALL, 3);
      recv(SPH_IMG_LARGE, 20, MAX_LARGE);
      recv(SPH_IMG_SMALL, 6, MAX_SMALL);
      recv(SPH_IMG_MEDIUM, 7, MAX_MEDIUM);
      results();
   end
endmodule
`default_nettype wire
